// ---- inc/blsl_params.svh ----
// Purpose: constants of the burner load and safety-loop input block
// Assumes: 100 MHz clock, second-resolution timers
// Notes: register byte addresses are word aligned
//
// Overview of operation
// - Each load input acts only on a 2-of-3 majority of samples.
// - Active heat request starts the burner sequence.
// - Heat request removed: burner shuts down, then goes to standby.
// - On heat removal actuator runs toward low-fire for shutdown running time.
// - Actuator stops at time expiry or low-fire, whichever first; then shutdown.
// - Shutdown running time zero: shut down leaving actuator where it was.
// - Postpurge after shutdown as set by postpurge time and multiplier.
// - CLOSED input is used only in operating phase, ignored elsewhere.
// - CLOSED active in operation drives actuator toward low-fire.
// - OPEN input is used only in operating phase, ignored elsewhere.
// - OPEN drives toward high-fire; neither active holds position.
// - Open safety loop removes power from valves, fan and igniter at once.
// - All safety contacts form one safety-loop status signal.
// - Safety loop open with heat request: lockout with error code 22.
// - Safety-loop supply on only with heat request, off in lockout.
// - Intermittent mode forces controlled shutdown after 24 h operation.
// - Actuator held at high-fire during prepurge; no drive when the actuator enable bit is cleared.
// - Combustion-control mode 1 has no function and forces lockout.
`ifndef BLSL_PARAMS_SVH
`define BLSL_PARAMS_SVH

`define BLSL_CLK_PERIOD_NS 10
`define BLSL_MS_NS 1000000
`define BLSL_MS_PER_S 1000
`define BLSL_SAMPLE_MS 150
`define BLSL_RUN_LIMIT_H 24
`define BLSL_S_PER_H 3600
`define BLSL_STAB_S 3

`define BLSL_ERR_NONE 8'h00
`define BLSL_ERR_LOOP 8'h16
`define BLSL_ERR_MODE 8'h3c
`define BLSL_MODE_NOFUNC 2'h1

`define BLSL_A_CTRL 4'h0
`define BLSL_A_TIMES 4'h4
`define BLSL_A_STATUS 4'h8
`define BLSL_A_RUNTIME 4'hc

`define BLSL_CTRL_INTERMIT 0
`define BLSL_CTRL_ACT_EN 1
`define BLSL_CTRL_MODE_LO 2
`define BLSL_CTRL_MODE_HI 3
`define BLSL_TM_SHUT_LO 0
`define BLSL_TM_SHUT_HI 7
`define BLSL_TM_PRE_LO 8
`define BLSL_TM_PRE_HI 15
`define BLSL_TM_PREM_LO 16
`define BLSL_TM_PREM_HI 19
`define BLSL_TM_POST_LO 20
`define BLSL_TM_POST_HI 27
`define BLSL_TM_POSTM_LO 28
`define BLSL_TM_POSTM_HI 31

`define BLSL_RST_INTERMIT 1'h0
`define BLSL_RST_ACT_EN 1'h1
`define BLSL_RST_MODE 2'h0
`define BLSL_RST_SHUT_S 8'h0a
`define BLSL_RST_PRE_S 8'h14
`define BLSL_RST_PRE_M 4'h1
`define BLSL_RST_POST_S 8'h0f
`define BLSL_RST_POST_M 4'h1

`endif

// ---- inc/blsl_pkg.sv ----
// Purpose: types of the burner load and safety-loop input block
// Assumes: nothing beyond the constants header
// Notes: all module state is held in the packed structs below
package blsl_pkg;

    typedef enum logic [2:0] {
        PH_STANDBY,
        PH_PREPURGE,
        PH_IGNITE,
        PH_OPERATE,
        PH_SHUT_RUN,
        PH_POSTPURGE,
        PH_LOCKOUT
    } blsl_phase_t;

    typedef struct packed {
        logic sy1;
        logic sy2;
        logic [2:0] hist;
        logic level;
    } blsl_vote_state_t;

    typedef struct packed {
        logic [3:0] sy1;
        logic [3:0] sy2;
        logic [16:0] ms_div;
        logic [9:0] ms_in_sec;
        logic [7:0] ms_in_sample;
        logic sample;
        blsl_phase_t phase;
        logic [16:0] phase_secs;
        logic [16:0] run_secs;
        logic [7:0] err;
        logic intermit_en;
        logic act_en;
        logic [1:0] comb_mode;
        logic [7:0] shut_s;
        logic [7:0] pre_s;
        logic [3:0] pre_m;
        logic [7:0] post_s;
        logic [3:0] post_m;
        logic fuel;
        logic fan;
        logic ign;
        logic to_low;
        logic to_high;
        logic supply;
        logic [31:0] rdata;
    } blsl_state_t;

endpackage : blsl_pkg

// ---- core/blsl_vote.sv ----
// Purpose: synchronise one load-controller pin and vote 2 of 3 samples
// Assumes: i_sample is a one-cycle strobe every sampling period
// Notes: level changes only after two agreeing samples
`timescale 1ns/1ps
module blsl_vote
    import blsl_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Sampling
    input wire logic i_pin,
    input wire logic i_sample,
    // Result
    output logic o_level
);

    blsl_vote_state_t r;
    blsl_vote_state_t next_r;

    always_comb begin
        next_r = r;
        next_r.sy1 = i_pin;
        next_r.sy2 = r.sy1;
        if (i_sample) begin
            next_r.hist = {r.hist[1:0], r.sy2};
            // Majority of the newest three samples
            next_r.level = (r.hist[0] & r.hist[1]) | (r.hist[0] & r.sy2) | (r.hist[1] & r.sy2);
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
        end else if (i_ce) begin
            r <= next_r;
        end
    end

    assign o_level = r.level;

endmodule : blsl_vote

// ---- core/blsl_top.sv ----
// Purpose: heat request, load controller and safety loop evaluation
// Assumes: pins are asynchronous; bus and lockout clear are on i_mclk
// Notes: phase timers count whole seconds from a 1 ms prescaler
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "blsl_params.svh"
module blsl_top
    import blsl_pkg::*;
#(
    parameter int MS_CYCLES = `BLSL_MS_NS / `BLSL_CLK_PERIOD_NS
)
(
    // Clock, reset and enable
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Terminal inputs
    input wire logic i_heat_request,
    input wire logic i_load_closed,
    input wire logic i_load_open,
    input wire logic i_safety_loop,
    // Actuator end switches
    input wire logic i_act_at_low_fire,
    input wire logic i_act_at_high_fire,
    // External lockout clear
    input wire logic i_lockout_clear,
    // Burner outputs
    output logic o_fuel_valve,
    output logic o_fan,
    output logic o_ignition,
    output logic o_act_to_low,
    output logic o_act_to_high,
    output logic o_safety_loop_supply,
    // Status
    output logic o_safety_loop_status,
    output logic o_lockout,
    output logic [7:0] o_err_code,
    output blsl_phase_t o_phase
);

    localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);
    localparam logic [9:0] SEC_LAST = 10'(`BLSL_MS_PER_S - 1);
    localparam logic [7:0] SAMPLE_LAST = 8'(`BLSL_SAMPLE_MS - 1);
    localparam logic [16:0] RUN_LIMIT_S = 17'(`BLSL_RUN_LIMIT_H * `BLSL_S_PER_H);
    localparam logic [16:0] STAB_S = 17'(`BLSL_STAB_S);

    blsl_state_t r;
    blsl_state_t next_r;

    logic closed_v;
    logic open_v;

    // Purge length in seconds; multiplier 0 counts as 1
    function automatic logic [16:0] blsl_purge_secs(input logic [7:0] secs, input logic [3:0] mult);
        logic [3:0] m;
        m = (mult == 4'h0) ? 4'h1 : mult;
        // Widen first so a long purge times multiplier cannot wrap
        blsl_purge_secs = 17'(secs) * 17'(m);
    endfunction : blsl_purge_secs

    blsl_vote u_vote_closed (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(i_load_closed),
        .i_sample(r.sample),
        .o_level(closed_v)
    );

    blsl_vote u_vote_open (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(i_load_open),
        .i_sample(r.sample),
        .o_level(open_v)
    );

    always_comb begin
        logic heat;
        logic safe;
        logic at_low;
        logic ms_tick;
        logic sec_tick;
        blsl_phase_t next_phase;
        logic operating;
        logic burning;

        next_r = r;
        heat = r.sy2[0];
        safe = r.sy2[1];
        at_low = r.sy2[2];
        next_phase = r.phase;

        // Pins pass two flops before use
        next_r.sy1 = {i_act_at_high_fire, i_act_at_low_fire, i_safety_loop, i_heat_request};
        next_r.sy2 = r.sy1;

        // Millisecond, second and sampling strobes
        ms_tick = (r.ms_div == MS_LAST);
        sec_tick = ms_tick && (r.ms_in_sec == SEC_LAST);
        next_r.ms_div = ms_tick ? 17'h00000 : r.ms_div + 17'h00001;
        next_r.sample = 1'b0;
        if (ms_tick) begin
            next_r.ms_in_sec = (r.ms_in_sec == SEC_LAST) ? 10'h000 : r.ms_in_sec + 10'h001;
            if (r.ms_in_sample == SAMPLE_LAST) begin
                next_r.ms_in_sample = 8'h00;
                next_r.sample = 1'b1;
            end else begin
                next_r.ms_in_sample = r.ms_in_sample + 8'h01;
            end
        end
        if (sec_tick) begin
            next_r.phase_secs = r.phase_secs + 17'h00001;
        end

        // Continuous operation time
        if (r.phase != PH_OPERATE) begin
            next_r.run_secs = 17'h00000;
        end else if (sec_tick) begin
            next_r.run_secs = r.run_secs + 17'h00001;
        end

        case (r.phase)
            PH_STANDBY: begin
                if (heat && safe) begin
                    next_phase = PH_PREPURGE;
                end
            end
            PH_PREPURGE: begin
                if (!heat) begin
                    next_phase = PH_STANDBY;
                end else if (r.phase_secs >= blsl_purge_secs(r.pre_s, r.pre_m)) begin
                    next_phase = PH_IGNITE;
                end
            end
            PH_IGNITE: begin
                if (!heat) begin
                    next_phase = PH_SHUT_RUN;
                end else if (r.phase_secs >= STAB_S) begin
                    next_phase = PH_OPERATE;
                end
            end
            PH_OPERATE: begin
                if (!heat) begin
                    next_phase = PH_SHUT_RUN;
                end else if (r.intermit_en && r.run_secs >= RUN_LIMIT_S) begin
                    next_phase = PH_SHUT_RUN;
                end
            end
            PH_SHUT_RUN: begin
                // Zero running time leaves the actuator where it stood
                if (r.shut_s == 8'h00) begin
                    next_phase = PH_POSTPURGE;
                end else if (at_low || !r.act_en || r.phase_secs >= {9'h000, r.shut_s}) begin
                    next_phase = PH_POSTPURGE;
                end
            end
            PH_POSTPURGE: begin
                if (r.phase_secs >= blsl_purge_secs(r.post_s, r.post_m)) begin
                    next_phase = PH_STANDBY;
                end
            end
            PH_LOCKOUT: begin
                // Only the external clear leaves lockout
                if (i_lockout_clear) begin
                    next_phase = PH_STANDBY;
                    next_r.err = `BLSL_ERR_NONE;
                end
            end
            default: begin
                next_phase = PH_LOCKOUT;
            end
        endcase

        // Fault checks override the sequence
        if (r.phase != PH_LOCKOUT) begin
            if (r.comb_mode == `BLSL_MODE_NOFUNC) begin
                next_phase = PH_LOCKOUT;
                next_r.err = `BLSL_ERR_MODE;
            end else if (heat && !safe) begin
                next_phase = PH_LOCKOUT;
                next_r.err = `BLSL_ERR_LOOP;
            end
        end

        if (next_phase != r.phase) begin
            next_r.phase_secs = 17'h00000;
        end
        next_r.phase = next_phase;

        // Outputs follow the next phase so they switch with it
        operating = (next_phase == PH_OPERATE);
        burning = (next_phase == PH_IGNITE) || operating || (next_phase == PH_SHUT_RUN);
        // Loop contacts cut power regardless of phase
        next_r.fuel = safe && burning;
        next_r.ign = safe && (next_phase == PH_IGNITE);
        next_r.fan = safe && (next_phase != PH_STANDBY) && (next_phase != PH_LOCKOUT);
        next_r.supply = heat && (next_phase != PH_LOCKOUT);

        // Load inputs only count in the operating phase
        next_r.to_high = 1'b0;
        next_r.to_low = 1'b0;
        if (r.act_en) begin
            if (next_phase == PH_PREPURGE) begin
                next_r.to_high = 1'b1;
            end else if (operating) begin
                next_r.to_high = open_v && !closed_v;
                next_r.to_low = closed_v && !open_v;
            end else if (next_phase == PH_SHUT_RUN) begin
                next_r.to_low = (r.shut_s != 8'h00) && !at_low;
            end
        end

        // Register writes
        if (i_wr) begin
            if (i_addr == `BLSL_A_CTRL) begin
                next_r.intermit_en = i_wdata[`BLSL_CTRL_INTERMIT];
                next_r.act_en = i_wdata[`BLSL_CTRL_ACT_EN];
                next_r.comb_mode = i_wdata[`BLSL_CTRL_MODE_HI:`BLSL_CTRL_MODE_LO];
            end else if (i_addr == `BLSL_A_TIMES) begin
                next_r.shut_s = i_wdata[`BLSL_TM_SHUT_HI:`BLSL_TM_SHUT_LO];
                next_r.pre_s = i_wdata[`BLSL_TM_PRE_HI:`BLSL_TM_PRE_LO];
                next_r.pre_m = i_wdata[`BLSL_TM_PREM_HI:`BLSL_TM_PREM_LO];
                next_r.post_s = i_wdata[`BLSL_TM_POST_HI:`BLSL_TM_POST_LO];
                next_r.post_m = i_wdata[`BLSL_TM_POSTM_HI:`BLSL_TM_POSTM_LO];
            end
        end

        // Read data stands for one cycle only
        next_r.rdata = 32'h00000000;
        if (i_rd) begin
            if (i_addr == `BLSL_A_CTRL) begin
                next_r.rdata = {28'h0000000, r.comb_mode, r.act_en, r.intermit_en};
            end else if (i_addr == `BLSL_A_TIMES) begin
                next_r.rdata = {r.post_m, r.post_s, r.pre_m, r.pre_s, r.shut_s};
            end else if (i_addr == `BLSL_A_STATUS) begin
                next_r.rdata = {16'h0000, r.err, (r.phase == PH_LOCKOUT), open_v, closed_v, heat, safe, r.phase};
            end else if (i_addr == `BLSL_A_RUNTIME) begin
                next_r.rdata = {15'h0000, r.run_secs};
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
            r.phase <= PH_STANDBY;
            r.err <= `BLSL_ERR_NONE;
            r.intermit_en <= `BLSL_RST_INTERMIT;
            r.act_en <= `BLSL_RST_ACT_EN;
            r.comb_mode <= `BLSL_RST_MODE;
            r.shut_s <= `BLSL_RST_SHUT_S;
            r.pre_s <= `BLSL_RST_PRE_S;
            r.pre_m <= `BLSL_RST_PRE_M;
            r.post_s <= `BLSL_RST_POST_S;
            r.post_m <= `BLSL_RST_POST_M;
        end else if (i_ce) begin
            r <= next_r;
        end
    end

    assign o_rdata = r.rdata;
    assign o_fuel_valve = r.fuel;
    assign o_fan = r.fan;
    assign o_ignition = r.ign;
    assign o_act_to_low = r.to_low;
    assign o_act_to_high = r.to_high;
    assign o_safety_loop_supply = r.supply;
    assign o_safety_loop_status = r.sy2[1];
    assign o_lockout = (r.phase == PH_LOCKOUT);
    assign o_err_code = r.err;
    assign o_phase = r.phase;

endmodule : blsl_top

// ---- tb/blsl_props.sv ----
// Purpose: port checker for the load and safety-loop block
// Assumes: pins pass two sync flops and one state flop
// Notes: bound from the bench top file
`timescale 1ns/1ps
`include "blsl_params.svh"
module blsl_props
    import blsl_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Pins
    input wire logic i_heat_request,
    input wire logic i_safety_loop,
    input wire logic i_act_at_low_fire,
    input wire logic i_lockout_clear,
    // Outputs
    input wire logic o_fuel_valve,
    input wire logic o_fan,
    input wire logic o_ignition,
    input wire logic o_act_to_low,
    input wire logic o_act_to_high,
    input wire logic o_safety_loop_supply,
    input wire logic o_lockout,
    input wire logic [7:0] o_err_code,
    input wire blsl_phase_t o_phase
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    sequence s_start;
        (i_heat_request && i_safety_loop && !i_lockout_clear && o_phase == PH_STANDBY)[*3];
    endsequence
    sequence s_open_heat;
        (i_heat_request && !i_safety_loop && !i_lockout_clear)[*4];
    endsequence
    sequence s_at_low;
        (o_phase == PH_SHUT_RUN && i_act_at_low_fire)[*3];
    endsequence
    property p_start; s_start |-> ##[1:2] o_phase == PH_PREPURGE; endproperty
    property p_open_heat; s_open_heat |=> o_lockout; endproperty
    property p_cut; !i_safety_loop[*3] |=> !o_fuel_valve && !o_fan && !o_ignition; endproperty
    property p_supply_off; !i_heat_request[*3] |=> !o_safety_loop_supply; endproperty
    property p_lock_supply; o_lockout |-> !o_safety_loop_supply; endproperty
    property p_lock_hold; o_lockout && !i_lockout_clear |=> o_lockout; endproperty
    property p_lock_code;
        $rose(o_lockout) |-> o_err_code == `BLSL_ERR_LOOP || o_err_code == `BLSL_ERR_MODE;
    endproperty
    property p_idle_drive;
        (o_phase inside {PH_STANDBY, PH_POSTPURGE, PH_LOCKOUT}) && $stable(o_phase)
            |-> !o_act_to_low && !o_act_to_high;
    endproperty
    property p_one_way; !(o_act_to_low && o_act_to_high); endproperty
    property p_low_end; s_at_low |=> o_phase != PH_SHUT_RUN; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    a_open_heat: assert property (p_open_heat) else $error("no lockout on open loop");
    a_cut: assert property (p_cut) else $error("loads not cut");
    a_supply_off: assert property (p_supply_off) else $error("supply without heat");
    a_lock_supply: assert property (p_lock_supply) else $error("supply in lockout");
    a_lock_hold: assert property (p_lock_hold) else $error("lockout left");
    a_lock_code: assert property (p_lock_code) else $error("bad lockout code");
    a_idle_drive: assert property (p_idle_drive) else $error("drive outside operation");
    a_one_way: assert property (p_one_way) else $error("both drives on");
    a_low_end: assert property (p_low_end) else $error("run past low-fire");
endmodule : blsl_props

// ---- tb/blsl_partner.sv ----
// Purpose: thermostat, load controller, safety contacts and actuator
// Assumes: wanted levels change on rising edges
// Notes: actuator moves one step a cycle between 0 and 200
`timescale 1ns/1ps
module blsl_partner (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Wanted levels
    input wire logic i_heat,
    input wire logic i_closed,
    input wire logic i_open,
    input wire logic i_loop,
    // Actuator drive
    input wire logic i_to_low,
    input wire logic i_to_high,
    // Pins
    output logic o_heat_request,
    output logic o_load_closed,
    output logic o_load_open,
    output logic o_safety_loop,
    output logic o_at_low,
    output logic o_at_high,
    output logic [7:0] o_pos
);
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_heat_request <= 1'b0;
            o_load_closed <= 1'b0;
            o_load_open <= 1'b0;
            o_safety_loop <= 1'b1;
            o_pos <= 8'h64;
        end else begin
            // Levels held as long as the bench wants them
            o_heat_request <= i_heat;
            o_load_closed <= i_closed;
            o_load_open <= i_open;
            o_safety_loop <= i_loop;
            if (i_to_low && o_pos != 8'h00)
                o_pos <= o_pos - 8'h01;
            else if (i_to_high && o_pos != 8'hc8)
                o_pos <= o_pos + 8'h01;
        end
    end
    assign o_at_low = o_pos == 8'h00;
    assign o_at_high = o_pos == 8'hc8;
endmodule : blsl_partner

// ---- tb/blsl_top_tb.sv ----
// Purpose: self-checking bench of the load and safety-loop block
// Assumes: 1 ms shortened to 2 cycles, so 1 s is 2000 cycles
// Notes: pins reach the block through the partner model
`timescale 1ns/1ps
`include "blsl_params.svh"
module blsl_top_tb
    import blsl_pkg::*;
;
    logic i_mclk, i_resetn, i_wr, i_rd, i_lockout_clear, ce;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic heat, closed, open_c, loop, hr, lc, lo, sl, al, ah;
    logic fuel, fan, ign, to_low, to_high, supply, loop_st, lock;
    logic [7:0] err, pos, saved;
    blsl_phase_t phase;
    int n_mismatch, tests_run;

    blsl_top #(.MS_CYCLES(2)) dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_heat_request(hr), .i_load_closed(lc), .i_load_open(lo), .i_safety_loop(sl),
        .i_act_at_low_fire(al), .i_act_at_high_fire(ah), .i_lockout_clear(i_lockout_clear),
        .o_fuel_valve(fuel), .o_fan(fan), .o_ignition(ign), .o_act_to_low(to_low),
        .o_act_to_high(to_high), .o_safety_loop_supply(supply), .o_safety_loop_status(loop_st),
        .o_lockout(lock), .o_err_code(err), .o_phase(phase));
    blsl_partner part_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_heat(heat), .i_closed(closed),
        .i_open(open_c), .i_loop(loop), .i_to_low(to_low), .i_to_high(to_high), .o_heat_request(hr),
        .o_load_closed(lc), .o_load_open(lo), .o_safety_loop(sl), .o_at_low(al), .o_at_high(ah),
        .o_pos(pos));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        // Ends off the launching edge so outputs are settled
        repeat (n) @(negedge i_mclk);
    endtask : cyc
    task automatic pins(input logic h, input logic c, input logic o, input logic l);
        @(posedge i_mclk);
        heat <= h;
        closed <= c;
        open_c <= o;
        loop <= l;
    endtask : pins
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(o_rdata, exp);
        @(negedge i_mclk);
        chk(o_rdata, 32'h0);
    endtask : rd
    task automatic clr();
        @(posedge i_mclk);
        i_lockout_clear <= 1'b1;
        @(posedge i_mclk);
        i_lockout_clear <= 1'b0;
    endtask : clr
    task automatic wait_ph(input blsl_phase_t ph, input int n);
        for (int i = 0; i < n && phase !== ph; i++)
            @(negedge i_mclk);
        chk(32'(phase), 32'(ph));
    endtask : wait_ph
    task automatic wait_act(input logic l, input logic h, input int n);
        for (int i = 0; i < n && {to_low, to_high} !== {l, h}; i++)
            @(negedge i_mclk);
        chk({to_low, to_high}, {l, h});
    endtask : wait_act

    task automatic t_regs();
        rd(`BLSL_A_CTRL, 32'h2);
        rd(`BLSL_A_TIMES, 32'h10f1140a);
        rd(4'h2, 32'h0);
        rd(`BLSL_A_RUNTIME, 32'h0);
        wr(`BLSL_A_STATUS, 32'hffffffff);
        rd(`BLSL_A_STATUS, 32'h8);
        // A write while the enable is low must be lost
        @(posedge i_mclk);
        ce <= 1'b0;
        wr(`BLSL_A_CTRL, 32'h1);
        ce <= 1'b1;
        rd(`BLSL_A_CTRL, 32'h2);
        wr(`BLSL_A_CTRL, 32'h3);
        rd(`BLSL_A_CTRL, 32'h3);
        wr(`BLSL_A_TIMES, 32'h10110102);
        rd(`BLSL_A_TIMES, 32'h10110102);
    endtask : t_regs
    task automatic t_start();
        pins(1, 0, 0, 1);
        wait_ph(PH_PREPURGE, 10);
        chk({fan, to_high, supply, fuel}, 4'b1110);
        pins(1, 1, 0, 1);
        cyc(1000);
        chk(to_low, 1'b0);
        pins(1, 0, 0, 1);
        wait_ph(PH_IGNITE, 2000);
        chk({ign, fuel, fan, to_low}, 4'b1110);
        wait_ph(PH_OPERATE, 14000);
    endtask : t_start
    task automatic t_load();
        // One short pulse can hit at most one sample
        pins(1, 1, 0, 1);
        cyc(250);
        pins(1, 0, 0, 1);
        cyc(700);
        chk(to_low, 1'b0);
        pins(1, 1, 0, 1);
        cyc(290);
        chk(to_low, 1'b0);
        wait_act(1, 0, 700);
        pins(1, 0, 1, 1);
        wait_act(0, 1, 1000);
        pins(1, 0, 0, 1);
        wait_act(0, 0, 1000);
    endtask : t_load
    task automatic t_shut();
        pins(0, 0, 0, 1);
        wait_ph(PH_SHUT_RUN, 10);
        chk(to_low, 1'b1);
        wait_ph(PH_POSTPURGE, 3000);
        chk({fan, fuel, to_low}, 3'b100);
        wait_ph(PH_STANDBY, 5000);
    endtask : t_shut
    task automatic t_zero();
        wr(`BLSL_A_TIMES, 32'h10110100);
        t_start();
        saved = pos;
        pins(0, 0, 0, 1);
        wait_ph(PH_POSTPURGE, 10);
        wait_ph(PH_STANDBY, 5000);
        chk(pos, saved);
    endtask : t_zero
    task automatic t_lock();
        pins(1, 0, 0, 1);
        wait_ph(PH_PREPURGE, 10);
        pins(1, 0, 0, 0);
        wait_ph(PH_LOCKOUT, 10);
        chk({fuel, fan, ign, supply, loop_st}, 5'h00);
        rd(`BLSL_A_STATUS, 32'h1696);
        pins(0, 0, 0, 1);
        cyc(50);
        chk(lock, 1'b1);
        clr();
        wait_ph(PH_STANDBY, 5);
        chk(err, `BLSL_ERR_NONE);
    endtask : t_lock
    task automatic t_mode();
        wr(`BLSL_A_CTRL, 32'h6);
        wait_ph(PH_LOCKOUT, 10);
        chk(err, `BLSL_ERR_MODE);
        wr(`BLSL_A_CTRL, 32'h0);
        clr();
        wait_ph(PH_STANDBY, 5);
        // No actuator fitted: no drive even in prepurge
        pins(1, 0, 0, 1);
        wait_ph(PH_PREPURGE, 10);
        chk({fan, to_high, to_low}, 3'b100);
        pins(0, 0, 0, 1);
        wait_ph(PH_STANDBY, 10);
    endtask : t_mode

    task automatic end_of_test();
        $display("mismatches %0d, compares %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (100000) @(posedge i_mclk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        i_resetn = 1'b0;
        {i_wr, i_rd, i_lockout_clear, heat, closed, open_c} = 6'h00;
        loop = 1'b1;
        ce = 1'b1;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        repeat (20) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_regs();
        t_start();
        t_load();
        t_shut();
        t_zero();
        t_lock();
        t_mode();
        end_of_test();
    end
endmodule : blsl_top_tb

bind blsl_top blsl_props props_u (.i_mclk, .i_resetn, .i_heat_request, .i_safety_loop,
    .i_act_at_low_fire, .i_lockout_clear, .o_fuel_valve, .o_fan, .o_ignition, .o_act_to_low,
    .o_act_to_high, .o_safety_loop_supply, .o_lockout, .o_err_code, .o_phase);
